// File: pkg/ucb_pkg.sv
package ucb_pkg;
   // register byte addresses on the bus
   localparam logic [7:0] ADR_CTRL_A = 8'h00;
   localparam logic [7:0] ADR_CTRL_B = 8'h04;
   localparam logic [7:0] ADR_DIVISOR = 8'h08;
   localparam logic [7:0] ADR_STATUS = 8'h0c;
   localparam logic [7:0] ADR_DATA = 8'h10;
   // sixteen samples per bit, sampled mid bit
   localparam logic [3:0] OVS_LAST = 4'hf;
   localparam logic [3:0] OVS_MID = 4'h7;
   // low speed adds a further divide by four
   localparam logic [1:0] PRE_LAST = 2'h3;
   // index of the last data bit per word length
   localparam logic [3:0] LAST_BIT_8 = 4'h7;
   localparam logic [3:0] LAST_BIT_9 = 4'h8;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [3:0] ONE4 = 4'h1;
   localparam logic [1:0] ONE2 = 2'h1;
   localparam logic [7:0] ONE8 = 8'h01;

   typedef struct packed {
      logic global_on;
      logic nine_bit_sel;
      logic parity_en;
      logic parity_odd_sel;
      logic two_stop_sel;
      logic send_break;
      logic rx_ninth_bit;
      logic tx_ninth_bit;
   } ucb_ctrl_a_type;

   typedef struct packed {
      logic tx_on;
      logic rx_on;
      logic baud_high_speed;
      logic addr_detect_en;
      logic rx_edge_wake_en;
      logic rx_irq_en;
      logic tx_idle_irq_en;
      logic tx_empty_irq_en;
   } ucb_ctrl_b_type;

   typedef struct packed {
      logic tx_idle_flag;
      logic tx_empty_flag;
      logic rx_idle_flag;
      logic rx_avail_flag;
      logic overrun_flag;
      logic framing_err_flag;
      logic parity_err_flag;
      logic noise_flag;
   } ucb_status_type;

   // idle and transmit empty flags set, error and receive data flags clear
   localparam ucb_status_type STAT_RESET = 8'he0;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ucb_tx_state_type;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ucb_rx_state_type;
endpackage

// File: verilog/ucb_uart_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - address detect on: word is address when its top bit is one.
// - address detect and receive irq on: an address word requests irq when it newly sets data available or overrun.
// - address detect on: words with address bit zero dropped, no irq.
// - wake enable set and unit clock off: receive falling edge requests wake.
// - no wake from receive edges while clock runs or wake enable clear.
// - wake request raises wake interrupt; software restarts unit clock.
// - receive irq enable: overrun or data available sets request flag.
// - transmit idle irq enable: idle flag setting sets request flag.
// - transmit empty irq enable: empty flag setting sets request flag.
// - bit timing from free running 8-bit timer, divisor and speed bit.
// - bit rate is clock over 64(N+1) low speed, 16(N+1) high speed.
// - divisor N is the unsigned 8-bit register value, 0 to 255.
// - frame is start, 8 or 9 data, optional parity, one or two stops.
// - after reset format is eight data, no parity, one stop.
// - data is sent and received least significant bit first.
// - transmitter and receiver independent but share format and rate.
// - all three enables set: pins act as serial out and serial in.
// - serial output idles high whenever no frame or break is sent.
// - global disable releases pins, empties buffer, discards residual data.
// - disable clears transmit and receive enables, break and error flags, sets idle flags.
// - disable keeps all other control bits and the divisor.
// - disable aborts transfers at once; re-enable resumes same configuration.
// - after off and on the unit keeps its prior configuration.
// - disable resets the baud timer counter.
// - length bit selects 8 or 9 bits; ninth bits held separately.
module ucb_uart_ctrl (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic o_wb_ack,
   output logic [31:0] o_wb_dat,
   input wire logic i_rxd,
   input wire logic i_unit_clk_off,
   output logic o_txd,
   output logic o_txd_oe,
   output logic o_rxd_sel,
   output logic o_irq_set,
   output logic o_wake_req
);

   typedef struct packed {
      ucb_pkg::ucb_ctrl_a_type ctrl_a;
      ucb_pkg::ucb_ctrl_b_type ctrl_b;
      logic [7:0] divisor;
      ucb_pkg::ucb_status_type stat;
      logic [8:0] tx_buf;
      logic [8:0] tx_sh;
      logic tx_par;
      ucb_pkg::ucb_tx_state_type tx_st;
      logic [3:0] tx_bit;
      logic [3:0] tx_ovs;
      logic [8:0] rx_sh;
      logic [7:0] rx_data;
      ucb_pkg::ucb_rx_state_type rx_st;
      logic [3:0] rx_bit;
      logic [3:0] rx_ovs;
      logic rx_perr;
      logic rx_noise;
      logic [2:0] sync;
      logic rx_lvl;
      logic [7:0] brg_cnt;
      logic [1:0] brg_pre;
      logic txd;
      logic txd_oe;
      logic rxd_sel;
      logic irq_set;
      logic wake_req;
      logic wb_ack;
      logic [31:0] wb_dat;
   } ucb_state_type;

   ucb_state_type s;
   ucb_state_type next_s;
   logic acc;
   logic bus_wr;
   logic bus_rd;
   logic run;
   logic tick;
   logic nine;
   logic lvl_new;
   logic fall;
   logic [8:0] rx_word;
   logic rx_addr;
   logic rx_done;
   logic rx_keep;

   // parity over the active data bits, odd type inverts
   function automatic logic ucb_par(input logic [8:0] d, input logic n9,
                                    input logic odd);
      ucb_par = ^(n9 ? d : {1'b0, d[7:0]}) ^ odd;
   endfunction

   function automatic logic [3:0] ucb_last_bit(input logic n9);
      ucb_last_bit = n9 ? ucb_pkg::LAST_BIT_9 : ucb_pkg::LAST_BIT_8;
   endfunction

   // bus access takes effect on the edge where the master sees ack
   assign acc = i_wb_cyc && i_wb_stb && s.wb_ack;
   assign bus_wr = acc && i_wb_we && i_wb_sel[0];
   assign bus_rd = acc && !i_wb_we;
   assign run = s.ctrl_a.global_on && !i_unit_clk_off;
   assign nine = s.ctrl_a.nine_bit_sel;

   // sample tick every (N+1) or 4(N+1) clocks, 16 per bit
   assign tick = run && (s.brg_cnt == '0) &&
                 (s.ctrl_b.baud_high_speed || s.brg_pre == ucb_pkg::PRE_LAST);

   // level only moves once second and third stage agree
   assign lvl_new = (s.sync[1] == s.sync[2]) ? s.sync[2] : s.rx_lvl;
   assign fall = s.rx_lvl && !lvl_new;

   // lsb first: 8-bit words sit in the top eight shift bits
   assign rx_word = nine ? s.rx_sh : {1'b0, s.rx_sh[8:1]};
   assign rx_addr = nine ? rx_word[8] : rx_word[7];
   assign rx_done = tick && s.rx_st == ucb_pkg::RX_STOP && s.rx_ovs == ucb_pkg::OVS_MID;
   assign rx_keep = !(s.ctrl_b.addr_detect_en && !rx_addr);

   // whole next state
   always_comb begin
      next_s = s;
      next_s.irq_set = 1'b0;
      next_s.wake_req = 1'b0;
      next_s.wb_ack = 1'b0;
      next_s.sync = {s.sync[1:0], i_rxd};
      next_s.rx_lvl = lvl_new;

      // bus answer one cycle after the request appears
      if (i_wb_cyc && i_wb_stb && !s.wb_ack) begin
         next_s.wb_ack = 1'b1;
         case (i_wb_adr)
            ucb_pkg::ADR_CTRL_A: next_s.wb_dat = {24'h0, s.ctrl_a[7:1], 1'b0};
            ucb_pkg::ADR_CTRL_B: next_s.wb_dat = {24'h0, s.ctrl_b};
            ucb_pkg::ADR_DIVISOR: next_s.wb_dat = {24'h0, s.divisor};
            ucb_pkg::ADR_STATUS: next_s.wb_dat = {24'h0, s.stat};
            ucb_pkg::ADR_DATA: next_s.wb_dat = {23'h0, s.ctrl_a.rx_ninth_bit, s.rx_data};
            default: next_s.wb_dat = 32'h0;
         endcase
      end

      // register writes; receive ninth bit is read only
      if (bus_wr) begin
         case (i_wb_adr)
            ucb_pkg::ADR_CTRL_A: begin
               next_s.ctrl_a = ucb_pkg::ucb_ctrl_a_type'(i_wb_dat[7:0]);
               next_s.ctrl_a.rx_ninth_bit = s.ctrl_a.rx_ninth_bit;
            end
            ucb_pkg::ADR_CTRL_B: next_s.ctrl_b = ucb_pkg::ucb_ctrl_b_type'(i_wb_dat[7:0]);
            ucb_pkg::ADR_DIVISOR: next_s.divisor = i_wb_dat[7:0];
            ucb_pkg::ADR_DATA: begin
               // writes while the buffer is full are dropped
               if (s.stat.tx_empty_flag && s.ctrl_a.global_on) begin
                  next_s.tx_buf = {s.ctrl_a.tx_ninth_bit, i_wb_dat[7:0]};
                  next_s.stat.tx_empty_flag = 1'b0;
                  next_s.stat.tx_idle_flag = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // data read clears available; a new word this cycle wins below
      if (bus_rd && i_wb_adr == ucb_pkg::ADR_DATA) begin
         next_s.stat.rx_avail_flag = 1'b0;
      end

      // free running baud timer, reload N at terminal count
      if (run) begin
         if (s.brg_cnt == '0) begin
            next_s.brg_cnt = s.divisor;
            next_s.brg_pre = s.brg_pre + ucb_pkg::ONE2;
         end else begin
            next_s.brg_cnt = s.brg_cnt - ucb_pkg::ONE8;
         end
      end

      // transmitter, shares format and tick with the receiver
      if (s.tx_st == ucb_pkg::TX_IDLE) begin
         if (run && s.ctrl_b.tx_on && !s.stat.tx_empty_flag && !s.ctrl_a.send_break) begin
            next_s.tx_sh = s.tx_buf;
            next_s.tx_par = ucb_par(s.tx_buf, nine, s.ctrl_a.parity_odd_sel);
            next_s.stat.tx_empty_flag = 1'b1;
            next_s.tx_st = ucb_pkg::TX_START;
            next_s.tx_ovs = '0;
            next_s.tx_bit = '0;
         end
      end else if (tick) begin
         next_s.tx_ovs = s.tx_ovs + ucb_pkg::ONE4;
         if (s.tx_ovs == ucb_pkg::OVS_LAST) begin
            case (s.tx_st)
               ucb_pkg::TX_START: next_s.tx_st = ucb_pkg::TX_DATA;
               ucb_pkg::TX_DATA: begin
                  next_s.tx_sh = s.tx_sh >> 1;
                  next_s.tx_bit = s.tx_bit + ucb_pkg::ONE4;
                  if (s.tx_bit == ucb_last_bit(nine)) begin
                     next_s.tx_bit = '0;
                     next_s.tx_st = s.ctrl_a.parity_en ? ucb_pkg::TX_PAR : ucb_pkg::TX_STOP;
                  end
               end
               ucb_pkg::TX_PAR: next_s.tx_st = ucb_pkg::TX_STOP;
               ucb_pkg::TX_STOP: begin
                  // stop bits always sent, a second one on request
                  if (s.ctrl_a.two_stop_sel && s.tx_bit == '0) begin
                     next_s.tx_bit = ucb_pkg::ONE4;
                  end else begin
                     next_s.tx_st = ucb_pkg::TX_IDLE;
                     if (next_s.stat.tx_empty_flag) begin
                        next_s.stat.tx_idle_flag = 1'b1;
                     end
                  end
               end
               default: next_s.tx_st = ucb_pkg::TX_IDLE;
            endcase
         end
      end

      // receiver: start on a falling edge, sample mid bit
      if (s.rx_st == ucb_pkg::RX_IDLE) begin
         if (run && s.ctrl_b.rx_on && fall) begin
            next_s.rx_st = ucb_pkg::RX_START;
            next_s.rx_ovs = '0;
            next_s.rx_bit = '0;
            next_s.rx_perr = 1'b0;
            next_s.rx_noise = 1'b0;
            next_s.stat.rx_idle_flag = 1'b0;
         end
      end else if (tick) begin
         next_s.rx_ovs = s.rx_ovs + ucb_pkg::ONE4;
         if (s.rx_ovs == ucb_pkg::OVS_MID) begin
            // stages still disagreeing at the sample point mean noise
            next_s.rx_noise = s.rx_noise | (s.sync[1] ^ s.sync[2]);
            case (s.rx_st)
               ucb_pkg::RX_START: begin
                  if (lvl_new) begin
                     next_s.rx_st = ucb_pkg::RX_IDLE;
                     next_s.stat.rx_idle_flag = 1'b1;
                  end
               end
               ucb_pkg::RX_DATA: next_s.rx_sh = {lvl_new, s.rx_sh[8:1]};
               ucb_pkg::RX_PAR: begin
                  next_s.rx_perr = lvl_new ^ ucb_par(rx_word, nine, s.ctrl_a.parity_odd_sel);
               end
               ucb_pkg::RX_STOP: begin
                  // leave at mid stop so the next start is not missed
                  next_s.rx_st = ucb_pkg::RX_IDLE;
                  next_s.stat.rx_idle_flag = 1'b1;
                  if (rx_keep) begin
                     if (s.stat.rx_avail_flag && next_s.stat.rx_avail_flag) begin
                        next_s.stat.overrun_flag = 1'b1;
                     end else begin
                        next_s.rx_data = rx_word[7:0];
                        next_s.ctrl_a.rx_ninth_bit = rx_word[8];
                        next_s.stat.rx_avail_flag = 1'b1;
                        next_s.stat.framing_err_flag = !lvl_new;
                        next_s.stat.parity_err_flag = s.rx_perr;
                        next_s.stat.noise_flag = next_s.rx_noise;
                     end
                  end
               end
               default: next_s.rx_st = ucb_pkg::RX_IDLE;
            endcase
         end
         if (s.rx_ovs == ucb_pkg::OVS_LAST) begin
            case (s.rx_st)
               ucb_pkg::RX_START: next_s.rx_st = ucb_pkg::RX_DATA;
               ucb_pkg::RX_DATA: begin
                  next_s.rx_bit = s.rx_bit + ucb_pkg::ONE4;
                  if (s.rx_bit == ucb_last_bit(nine)) begin
                     next_s.rx_st = s.ctrl_a.parity_en ? ucb_pkg::RX_PAR : ucb_pkg::RX_STOP;
                  end
               end
               ucb_pkg::RX_PAR: next_s.rx_st = ucb_pkg::RX_STOP;
               default: ;
            endcase
         end
      end

      // wake only counts while the unit clock is stopped
      if (s.ctrl_b.rx_edge_wake_en && i_unit_clk_off && fall) begin
         next_s.wake_req = 1'b1;
      end

      // per-direction enables abort their own engine
      if (!next_s.ctrl_b.tx_on) begin
         next_s.tx_st = ucb_pkg::TX_IDLE;
      end
      if (!next_s.ctrl_b.rx_on) begin
         next_s.rx_st = ucb_pkg::RX_IDLE;
         next_s.stat.rx_idle_flag = 1'b1;
      end

      // global off: abort, flush, reset flags, keep configuration
      if (!next_s.ctrl_a.global_on) begin
         next_s.ctrl_b.tx_on = 1'b0;
         next_s.ctrl_b.rx_on = 1'b0;
         next_s.ctrl_a.send_break = 1'b0;
         next_s.stat = ucb_pkg::STAT_RESET;
         next_s.tx_st = ucb_pkg::TX_IDLE;
         next_s.rx_st = ucb_pkg::RX_IDLE;
         next_s.brg_cnt = next_s.divisor;
         next_s.brg_pre = '0;
      end

      // serial output high unless a frame or break is on the line
      case (next_s.tx_st)
         ucb_pkg::TX_START: next_s.txd = 1'b0;
         ucb_pkg::TX_DATA: next_s.txd = next_s.tx_sh[0];
         ucb_pkg::TX_PAR: next_s.txd = next_s.tx_par;
         default: next_s.txd = 1'b1;
      endcase
      // break holds low only while software keeps the bit set
      if (next_s.ctrl_a.send_break) begin
         next_s.txd = 1'b0;
      end
      next_s.txd_oe = next_s.ctrl_a.global_on && next_s.ctrl_b.tx_on;
      next_s.rxd_sel = next_s.ctrl_a.global_on && next_s.ctrl_b.rx_on;

      // one pulse on any enabled flag rising
      next_s.irq_set =
         (s.ctrl_b.rx_irq_en &&
          ((next_s.stat.rx_avail_flag && !s.stat.rx_avail_flag) ||
           (next_s.stat.overrun_flag && !s.stat.overrun_flag))) ||
         (s.ctrl_b.tx_idle_irq_en &&
          next_s.stat.tx_idle_flag && !s.stat.tx_idle_flag) ||
         (s.ctrl_b.tx_empty_irq_en &&
          next_s.stat.tx_empty_flag && !s.stat.tx_empty_flag);
   end

   // state register; reset format is 8 data, no parity, one stop
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         s <= '0;
         s.divisor <= ucb_pkg::DIV_RESET;
         s.brg_cnt <= ucb_pkg::DIV_RESET;
         s.stat <= ucb_pkg::STAT_RESET;
         s.tx_st <= ucb_pkg::TX_IDLE;
         s.rx_st <= ucb_pkg::RX_IDLE;
         s.sync <= 3'h7;
         s.rx_lvl <= 1'b1;
         s.txd <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign o_wb_ack = s.wb_ack;
   assign o_wb_dat = s.wb_dat;
   assign o_txd = s.txd;
   assign o_txd_oe = s.txd_oe;
   assign o_rxd_sel = s.rxd_sel;
   assign o_irq_set = s.irq_set;
   assign o_wake_req = s.wake_req;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);

   tx_idle_high_a: assert property (
      (s.tx_st == ucb_pkg::TX_IDLE && !s.ctrl_a.send_break) |-> o_txd)
      else $error("serial out not high while idle");
   disable_flags_a: assert property (
      !s.ctrl_a.global_on |-> (s.stat == ucb_pkg::STAT_RESET && !s.ctrl_b.tx_on
                               && !s.ctrl_b.rx_on && !o_txd_oe))
      else $error("flags not reset while disabled");
   // the disabling write itself targets control a, so divisor and control b bits 5 to 0 must hold
   keep_config_a: assert property (
      $fell(s.ctrl_a.global_on) |->
      (s.divisor == $past(s.divisor) && s.ctrl_b[5:0] == $past(s.ctrl_b[5:0])))
      else $error("configuration changed on disable");
   baud_reload_a: assert property (
      (run && s.brg_cnt == '0 && s.ctrl_a.global_on) |=>
      (s.brg_cnt == $past(s.divisor) || !s.ctrl_a.global_on))
      else $error("baud timer did not reload divisor");
   baud_reset_a: assert property (
      !s.ctrl_a.global_on |-> (s.brg_cnt == s.divisor && s.brg_pre == '0))
      else $error("baud timer not reset while disabled");
   addr_drop_a: assert property (
      (rx_done && !rx_keep && s.ctrl_a.global_on) |=>
      (s.stat.rx_avail_flag == $past(s.stat.rx_avail_flag) || $past(bus_rd)) ##0 !o_irq_set)
      else $error("data word accepted under address detect");
   rx_irq_a: assert property (
      ($rose(s.stat.rx_avail_flag) && $past(s.ctrl_b.rx_irq_en)) |-> o_irq_set)
      else $error("receive irq missing");
   tx_empty_irq_a: assert property (
      ($rose(s.stat.tx_empty_flag) && $past(s.ctrl_b.tx_empty_irq_en)) |-> o_irq_set)
      else $error("transmit empty irq missing");
   no_wake_a: assert property (
      (!$past(i_unit_clk_off) || !$past(s.ctrl_b.rx_edge_wake_en)) |-> !o_wake_req)
      else $error("wake while clock running or wake disabled");
   ack_pulse_a: assert property (
      o_wb_ack |=> !o_wb_ack)
      else $error("ack held longer than one cycle");

   rx_word_c: cover property ($rose(s.stat.rx_avail_flag));
   tx_frame_c: cover property ($rose(s.stat.tx_idle_flag) && s.ctrl_a.global_on);
   wake_c: cover property (o_wake_req);
   overrun_c: cover property ($rose(s.stat.overrun_flag));
endmodule

// File: tb/ucb_remote_model.sv
`timescale 1ns/1ps
// remote transceiver on the line: 8 data bits, no parity, one stop
module ucb_remote_model (
   input wire logic i_clk_sys,
   input wire logic i_txd,
   output logic o_rxd
);
   int bit_clks = 32;
   logic [7:0] got_q[$];
   // line idles high between frames
   initial o_rxd = 1'b1;
   // one frame: start low, data lsb first, stop high
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         o_rxd <= f[i];
         repeat (bit_clks) @(posedge i_clk_sys);
      end
   endtask
   // capture frames mid bit; a low stop bit drops the word
   always begin
      logic [7:0] b;
      @(negedge i_txd);
      repeat (bit_clks / 2) @(posedge i_clk_sys);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_clks) @(posedge i_clk_sys);
         b[i] = i_txd;
      end
      repeat (bit_clks) @(posedge i_clk_sys);
      if (i_txd === 1'b1) got_q.push_back(b);
   end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic i_clk_sys = 1'b0;
   logic i_rstn = 1'b0;
   logic i_wb_cyc = 1'b0;
   logic i_wb_stb = 1'b0;
   logic i_wb_we = 1'b0;
   logic [7:0] i_wb_adr = 8'h00;
   logic [3:0] i_wb_sel = 4'h0;
   logic [31:0] i_wb_dat = 32'h0;
   logic i_unit_clk_off = 1'b0;
   logic o_wb_ack, rxd_line, o_txd, o_txd_oe, o_rxd_sel, o_irq_set, o_wake_req;
   logic [31:0] o_wb_dat;
   logic [31:0] q;
   logic [7:0] b;
   int fails = 0;
   int comparisons = 0;
   int irq_cnt = 0;
   int wake_cnt = 0;
   int exp_irq = 0;
   int seed = 70193;
   always #2.5 i_clk_sys = ~i_clk_sys;
   ucb_uart_ctrl dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc),
      .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
      .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_rxd(rxd_line),
      .i_unit_clk_off(i_unit_clk_off), .o_txd(o_txd), .o_txd_oe(o_txd_oe),
      .o_rxd_sel(o_rxd_sel), .o_irq_set(o_irq_set), .o_wake_req(o_wake_req));
   ucb_remote_model remote (.i_clk_sys(i_clk_sys), .i_txd(o_txd), .o_rxd(rxd_line));
   // tally one-cycle request pulses
   always @(posedge i_clk_sys) begin
      if (o_irq_set === 1'b1) irq_cnt++;
      if (o_wake_req === 1'b1) wake_cnt++;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // classic cycle, held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= adr;
      i_wb_dat <= d;
      i_wb_sel <= 4'hf;
      // no local limit: only the watchdog may end this wait
      do begin
         @(posedge i_clk_sys);
      end while (o_wb_ack !== 1'b1);
      q = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      i_wb_we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] adr, input logic [7:0] v);
      wb(1'b1, adr, {24'h0, v});
   endtask
   task automatic rd(input logic [7:0] adr);
      wb(1'b0, adr, 32'h0);
   endtask
   // send one byte, wait for the far end to frame it, then idle
   task automatic tx_check(input logic [7:0] v);
      int n;
      n = 0;
      wr(ucb_pkg::ADR_DATA, v);
      while (remote.got_q.size() == 0 && n < 3000) begin
         @(posedge i_clk_sys);
         n++;
      end
      if (remote.got_q.size() == 0) chk(32'h1, 32'h0);
      else chk({24'h0, remote.got_q.pop_front()}, {24'h0, v});
      repeat (remote.bit_clks) @(posedge i_clk_sys);
      exp_irq += 2;
      chk(32'(irq_cnt), 32'(exp_irq));
      chk({31'h0, o_txd}, 32'h1);
   endtask
   task automatic finish_test();
      $display("comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // cut a hang short well past the expected run length
   initial begin
      #300000;
      fails++;
      finish_test();
   end
   initial begin
      repeat (4) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      rd(ucb_pkg::ADR_CTRL_A);
      chk(q, 32'h0);
      rd(ucb_pkg::ADR_CTRL_B);
      chk(q, 32'h0);
      rd(ucb_pkg::ADR_STATUS);
      chk(q, 32'he0);
      rd(8'h20);
      chk(q, 32'h0);
      chk({31'h0, o_txd}, 32'h1);
      // wake only while the unit clock is off and wake is enabled
      wr(ucb_pkg::ADR_CTRL_A, 8'h80);
      wr(ucb_pkg::ADR_CTRL_B, 8'h08);
      remote.send(8'hff);
      chk(32'(wake_cnt), 32'h0);
      i_unit_clk_off <= 1'b1;
      remote.send(8'hff);
      chk(32'(wake_cnt), 32'h1);
      wr(ucb_pkg::ADR_CTRL_B, 8'h00);
      remote.send(8'hff);
      chk(32'(wake_cnt), 32'h1);
      i_unit_clk_off <= 1'b0;
      // receive with and without address detect, high speed N=1
      wr(ucb_pkg::ADR_DIVISOR, 8'h01);
      for (int i = 0; i < 4; i++) begin
         wr(ucb_pkg::ADR_CTRL_B, (i < 2) ? 8'hf4 : 8'he4);
         // pin enables are registered on the write edge, look one edge later
         @(posedge i_clk_sys);
         chk({30'h0, o_txd_oe, o_rxd_sel}, 32'h3);
         b = 8'($random(seed));
         b[7] = i[0];
         remote.send(b);
         repeat (40) @(posedge i_clk_sys);
         rd(ucb_pkg::ADR_STATUS);
         chk({31'h0, q[4]}, {31'h0, (i >= 2) || b[7]});
         if ((i >= 2) || b[7]) begin
            exp_irq++;
            rd(ucb_pkg::ADR_DATA);
            chk({24'h0, q[7:0]}, {24'h0, b});
         end
         chk(32'(irq_cnt), 32'(exp_irq));
      end
      // two words left unread: the second is dropped and flags overrun
      remote.send(8'h5a);
      remote.send(8'ha5);
      repeat (40) @(posedge i_clk_sys);
      exp_irq += 2;
      rd(ucb_pkg::ADR_STATUS);
      chk({30'h0, q[4:3]}, 32'h3);
      rd(ucb_pkg::ADR_DATA);
      chk(q, 32'h5a);
      chk(32'(irq_cnt), 32'(exp_irq));
      // transmit at low speed N=0 then high speed N=1
      for (int s = 0; s < 2; s++) begin
         wr(ucb_pkg::ADR_DIVISOR, 8'(s));
         wr(ucb_pkg::ADR_CTRL_B, s ? 8'he3 : 8'hc3);
         remote.bit_clks = s ? 32 : 64;
         tx_check(8'($random(seed)));
      end
      // disable in mid frame with irqs off
      wr(ucb_pkg::ADR_CTRL_B, 8'he0);
      wr(ucb_pkg::ADR_CTRL_A, 8'h98);
      wr(ucb_pkg::ADR_DATA, 8'($random(seed)));
      repeat (100) @(posedge i_clk_sys);
      wr(ucb_pkg::ADR_CTRL_A, 8'h18);
      repeat (2) @(posedge i_clk_sys);
      chk({29'h0, o_txd_oe, o_rxd_sel, o_txd}, 32'h1);
      rd(ucb_pkg::ADR_CTRL_A);
      chk(q, 32'h18);
      rd(ucb_pkg::ADR_CTRL_B);
      chk(q, 32'h20);
      rd(ucb_pkg::ADR_DIVISOR);
      chk(q, 32'h1);
      rd(ucb_pkg::ADR_STATUS);
      chk(q, 32'he0);
      repeat (700) @(posedge i_clk_sys);
      remote.got_q.delete();
      // back on: same divisor, same speed
      wr(ucb_pkg::ADR_CTRL_A, 8'h80);
      wr(ucb_pkg::ADR_CTRL_B, 8'he3);
      tx_check(8'($random(seed)));
      finish_test();
   end
endmodule
